//--- logic/oog_map.svh
// Register word indices, field positions, reset values and timing counts of the overlay generator
`ifndef OOG_MAP_SVH
`define OOG_MAP_SVH
// Word indices; the byte address is four times the index
`define OOG_CTRL 5'd0
`define OOG_BLINK 5'd1
`define OOG_BLEND 5'd2
`define OOG_CHARSZ 5'd3
`define OOG_CHARPOS 5'd4
`define OOG_FONTBASE 5'd5
`define OOG_FBFONT0 5'd6
`define OOG_MAPADDR 5'd10
`define OOG_MAPDATA 5'd11
`define OOG_CLUTADDR 5'd12
`define OOG_CLUTDATA 5'd13
`define OOG_STATUS 5'd14
`define OOG_SPARE 5'd15
`define OOG_WIN0 5'd16
`define OOG_BMP0 5'd20
`define OOG_LAST_IDX 5'd27
`define OOG_RST_VALUE 32'h0000_0000
// Control register fields
`define OOG_CHAR_EN 0
`define OOG_TWO_BIT 1
`define OOG_WIN_MODE 2
`define OOG_BLINK_EN 3
`define OOG_BMP0_EN 4
`define OOG_HSTR 9:8
`define OOG_VSTR 11:10
`define OOG_HSPACE 15:12
`define OOG_VSPACE 19:16
// Sizes and pipeline timing
`define OOG_FONT_LINES 12'd18
`define OOG_MAP_WORDS 3594
`define OOG_CLUT_WORDS 256
`define OOG_PIPE_CYCLES 3
`endif

//--- logic/oog_pkg.sv
// Types shared by the overlay generator and its bench
package oog_pkg;
    typedef struct packed {
        logic den;
        logic hs;
        logic vs;
        logic [23:0] rgb;
    } oog_video_s;
    typedef struct packed {
        logic [2:0] rd;
        logic [2:0][23:0] addr;
    } oog_fb_req_s;
    typedef logic [2:0][31:0] oog_fb_word_t;
endpackage : oog_pkg

//--- logic/oog_overlay_generator.sv
// OSD overlay generator: APB registers, character and bitmap resolution, colour table, blending
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "oog_map.svh"

// Contract
// R1: One-bit attribute: index 7..0, foreground 23..16, background bits 7..1 from 15..9.
// R2: One-bit attribute background colour always has bit 0 cleared.
// R3: Attribute bit 8 blinks the character only while global blink is enabled.
// R4: Blink-off phase shows background instead of foreground; period and duty programmable.
// R5: Row bit 3 two-colour frame-buffer font takes background from index bits 7..1.
// R6: Two-bit mode: shared upper bits 23..20, colour 3 low 19..17, colour 2 low 15..12.
// R7: Two-bit colour 1 takes bits 11..9 with bit 0 forced to zero.
// R8: Pixel codes 11, 10, 01 pick colours 3, 2, 1; 00 picks background.
// R9: Up to 256 on-chip one-bit glyphs of 12 by 18; 1 foreground, 0 background.
// R10: Frame-buffer glyph lines up to 16 by 24 are fetched; width must be even.
// R11: Each frame-buffer row selects one of four font tables, 1024 characters.
// R12: Four prioritised background windows by column and row; colour 00 transparent.
// R13: Without windows: per-character background in one-bit, colour 2 in two-bit mode.
// R14: Spacing pixels of background colour are added before stretching.
// R15: Bitmaps fetched at 8, 4, 2 or 1 bits per pixel, up to 512 by 512.
// R16: Codes map through a 256 by 24-bit host-loaded table; code 00 transparent.
// R17: Two bitmaps and one character image may show at once.
// R18: Stretch by one to four, pixel repeat horizontally, line repeat vertically.
// R19: One blend level for codes 128 and up, another for 127 and below.
// R20: Blend code gives overlay fraction of sixteen minus code over sixteen.
// R21: Rotated maps start bottom-left; software programs rotated sizes. The code has no rotation: maps always start at row 0, top-left.
// R22: Row bit 2 selects frame-buffer fonts, bits 1..0 pick the table.
// R23: Blink counter advances once per frame at vertical sync edge.
module oog_overlay_generator #(
    parameter int MAP_DEPTH = `OOG_MAP_WORDS, // Words of character map and font RAM
    parameter int CLUT_DEPTH = `OOG_CLUT_WORDS // Colour table entries
) (
    input wire logic clock, // 10 MHz pixel clock
    input wire logic reset, // Synchronous, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire oog_pkg::oog_video_s video_in, // Underlying image
    output oog_pkg::oog_video_s video_out, // Blended image
    output oog_pkg::oog_fb_req_s fb_req, // Frame buffer read lanes
    input wire oog_pkg::oog_fb_word_t fb_data // Lane data in the same cycle as the registered request
);
    import oog_pkg::*;

    // ==========================================================
    // Register bus
    logic [31:0] cfg_reg [0:31];
    logic [23:0] map_mem [0:MAP_DEPTH-1];
    logic [23:0] clut_mem [0:CLUT_DEPTH-1];
    logic [31:0] prdata_reg;
    logic [7:0] blink_cnt_reg;
    logic blink_off;
    logic setup, access, mapped, cfg_wr;
    logic [4:0] widx;

    assign widx = paddr[6:2];
    assign mapped = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0) &&
                    (widx <= `OOG_LAST_IDX) && (widx != `OOG_SPARE);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign cfg_wr = access && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_reg;

    // Read data is captured in the setup cycle so it is ready in the access cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            if (!mapped) begin
                prdata_reg <= 32'h0000_0000;
            end else begin
                case (widx)
                    `OOG_MAPDATA: prdata_reg <= {8'h00, map_mem[cfg_reg[`OOG_MAPADDR][11:0]]};
                    `OOG_CLUTDATA: prdata_reg <= {8'h00, clut_mem[cfg_reg[`OOG_CLUTADDR][7:0]]};
                    `OOG_STATUS: prdata_reg <= {23'h000000, blink_off, blink_cnt_reg};
                    default: prdata_reg <= cfg_reg[widx];
                endcase
            end
        end
    end

    // Data ports advance their address after every access
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                cfg_reg[i] <= `OOG_RST_VALUE;
            end
        end else begin
            if (cfg_wr && widx != `OOG_MAPDATA && widx != `OOG_CLUTDATA && widx != `OOG_STATUS)
                cfg_reg[widx] <= pwdata;
            if (access && mapped && widx == `OOG_MAPDATA)
                cfg_reg[`OOG_MAPADDR] <= cfg_reg[`OOG_MAPADDR] + 32'h0000_0001;
            if (access && mapped && widx == `OOG_CLUTDATA)
                cfg_reg[`OOG_CLUTADDR] <= cfg_reg[`OOG_CLUTADDR] + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (cfg_wr && widx == `OOG_MAPDATA)
            map_mem[cfg_reg[`OOG_MAPADDR][11:0]] <= pwdata[23:0];
        if (cfg_wr && widx == `OOG_CLUTDATA)
            clut_mem[cfg_reg[`OOG_CLUTADDR][7:0]] <= pwdata[23:0]; // [R16]
    end

    // ==========================================================
    // Fields and raster position
    logic [31:0] ctrl;
    logic [1:0] hf, vf;
    logic [7:0] cols, rows;
    logic [4:0] gw, gh, cell_w, cell_h;
    logic [11:0] x_reg, y_reg;
    logic den_d, vs_d, line_end, vs_rise;

    assign ctrl = cfg_reg[`OOG_CTRL];
    assign hf = ctrl[`OOG_HSTR];
    assign vf = ctrl[`OOG_VSTR];
    assign cols = cfg_reg[`OOG_CHARSZ][7:0];
    assign rows = cfg_reg[`OOG_CHARSZ][15:8];
    assign gw = cfg_reg[`OOG_CHARSZ][20:16];
    assign gh = cfg_reg[`OOG_CHARSZ][28:24];
    assign cell_w = gw + {1'b0, ctrl[`OOG_HSPACE]};
    assign cell_h = gh + {1'b0, ctrl[`OOG_VSPACE]};
    assign line_end = den_d && !video_in.den;
    assign vs_rise = video_in.vs && !vs_d;

    always_ff @(posedge clock) begin
        if (reset) begin
            den_d <= 1'b0;
            vs_d <= 1'b0;
            x_reg <= 12'h000;
            y_reg <= 12'h000;
        end else begin
            den_d <= video_in.den;
            vs_d <= video_in.vs;
            x_reg <= video_in.den ? x_reg + 12'h001 : 12'h000;
            if (vs_rise)
                y_reg <= 12'h000;
            else if (line_end)
                y_reg <= y_reg + 12'h001;
        end
    end

    // ==========================================================
    // Blink phase
    always_ff @(posedge clock) begin
        if (reset)
            blink_cnt_reg <= 8'h00;
        else if (vs_rise)
            blink_cnt_reg <= (blink_cnt_reg >= cfg_reg[`OOG_BLINK][7:0] - 8'h01) ?
                             8'h00 : blink_cnt_reg + 8'h01; // [R23]
    end
    assign blink_off = ctrl[`OOG_BLINK_EN] &&
                       blink_cnt_reg >= cfg_reg[`OOG_BLINK][15:8]; // [R3] [R4]

    // ==========================================================
    // Stretched coordinates; image 0 is the character map, 1 and 2 the bitmaps
    for (genvar i = 0; i < 3; i++) begin : g_img
        localparam int PREG = (i == 0) ? `OOG_CHARPOS : `OOG_BMP0 + 4 * i - 3;
        logic [11:0] ox, oy;
        logic [1:0] hrep, vrep;
        logic [9:0] px, py;
        logic adv_h, adv_v;
        assign ox = cfg_reg[PREG][11:0];
        assign oy = cfg_reg[PREG][27:16];
        assign adv_h = video_in.den && x_reg >= ox && hrep == hf; // [R18]
        assign adv_v = line_end && y_reg >= oy && vrep == vf; // [R18]
        always_ff @(posedge clock) begin
            if (reset || !video_in.den) begin
                hrep <= 2'h0;
                px <= 10'h000;
            end else if (x_reg >= ox) begin
                hrep <= adv_h ? 2'h0 : hrep + 2'h1;
                if (adv_h && px != 10'h3FF)
                    px <= px + 10'h001;
            end
        end
        always_ff @(posedge clock) begin
            if (reset || vs_rise) begin
                vrep <= 2'h0;
                py <= 10'h000;
            end else if (line_end && y_reg >= oy) begin
                vrep <= adv_v ? 2'h0 : vrep + 2'h1;
                if (adv_v && py != 10'h3FF)
                    py <= py + 10'h001;
            end
        end
    end

    // ==========================================================
    // Character cells, spacing counted in unstretched pixels
    logic [4:0] cx_reg, cy_reg, crow_reg;
    logic [5:0] ccol_reg;

    always_ff @(posedge clock) begin
        if (reset || !video_in.den) begin
            cx_reg <= 5'h00;
            ccol_reg <= 6'h00;
        end else if (g_img[0].adv_h) begin
            if (cx_reg == cell_w - 5'h01) begin
                cx_reg <= 5'h00;
                if (ccol_reg != 6'h3F)
                    ccol_reg <= ccol_reg + 6'h01;
            end else begin
                cx_reg <= cx_reg + 5'h01; // [R14]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset || vs_rise) begin
            cy_reg <= 5'h00;
            crow_reg <= 5'h00;
        end else if (g_img[0].adv_v) begin
            if (cy_reg == cell_h - 5'h01) begin
                cy_reg <= 5'h00;
                if (crow_reg != 5'h1F)
                    crow_reg <= crow_reg + 5'h01;
            end else begin
                cy_reg <= cy_reg + 5'h01; // [R14]
            end
        end
    end

    // ==========================================================
    // Character fetch: row word, attribute word, on-chip glyph line
    logic [11:0] row_base, font_addr, font_base;
    logic [23:0] attr, rattr, fword, fshift;
    logic [7:0] idx;
    logic [1:0] on_code;
    logic char_act, glyph_in, fb_font, win_hit;
    logic [7:0] win_col;

    assign row_base = {7'h00, crow_reg} * ({4'h0, cols} + 12'h001);
    assign rattr = map_mem[row_base];
    assign attr = map_mem[row_base + {6'h00, ccol_reg} + 12'h001];
    assign idx = attr[7:0]; // [R1]
    assign fb_font = rattr[2]; // [R22]
    assign char_act = ctrl[`OOG_CHAR_EN] && video_in.den && x_reg >= g_img[0].ox &&
                      y_reg >= g_img[0].oy && {2'h0, ccol_reg} < cols && {3'h0, crow_reg} < rows;
    assign glyph_in = cx_reg < gw && cy_reg < gh; // [R14]
    assign font_base = cfg_reg[`OOG_FONTBASE][11:0];
    assign font_addr = ctrl[`OOG_TWO_BIT] ?
                       font_base + {4'h0, idx} * `OOG_FONT_LINES + {7'h00, cy_reg} :
                       font_base + {5'h00, idx[7:1]} * `OOG_FONT_LINES + {7'h00, cy_reg}; // [R9]
    assign fword = map_mem[font_addr];
    // One-bit glyph words hold two glyphs, odd index in the upper twelve bits
    assign fshift = ctrl[`OOG_TWO_BIT] ? fword >> {cx_reg, 1'b0} :
                    fword >> (idx[0] ? cx_reg + 5'h0C : cx_reg);
    assign on_code = ctrl[`OOG_TWO_BIT] ? fshift[1:0] : {2{fshift[0]}}; // [R9]

    // Window 0 has the highest priority
    always_comb begin
        win_hit = 1'b0;
        win_col = 8'h00;
        for (int w = 3; w >= 0; w--) begin
            if (ctrl[`OOG_WIN_MODE] && ccol_reg >= cfg_reg[`OOG_WIN0 + w][13:8] &&
                ccol_reg <= cfg_reg[`OOG_WIN0 + w][19:14] &&
                crow_reg >= cfg_reg[`OOG_WIN0 + w][24:20] &&
                crow_reg <= cfg_reg[`OOG_WIN0 + w][29:25]) begin
                win_hit = 1'b1;
                win_col = cfg_reg[`OOG_WIN0 + w][7:0]; // [R12]
            end
        end
    end

    // ==========================================================
    // Bitmaps: address of the word holding the pixel, then pixel extraction
    for (genvar j = 0; j < 2; j++) begin : g_bmp
        localparam int BREG = `OOG_BMP0 + 4 * j;
        logic [1:0] bpp, bpp_reg;
        logic [9:0] bw, bh;
        logic [19:0] pix;
        logic [22:0] bitoff;
        logic [4:0] sel_reg;
        logic act, act_reg;
        logic [31:0] word;
        logic [7:0] code;
        assign bpp = cfg_reg[BREG + 3][1:0];
        assign bw = cfg_reg[BREG + 2][9:0];
        assign bh = cfg_reg[BREG + 2][25:16];
        assign pix = {10'h000, g_img[j + 1].py} * {10'h000, bw} + {10'h000, g_img[j + 1].px};
        assign bitoff = {3'h0, pix} << (2'h3 - bpp); // [R15]
        assign act = ctrl[`OOG_BMP0_EN + j] && video_in.den && x_reg >= g_img[j + 1].ox &&
                     y_reg >= g_img[j + 1].oy && g_img[j + 1].px < bw && g_img[j + 1].py < bh;
        always_ff @(posedge clock) begin
            if (reset) begin
                act_reg <= 1'b0;
                sel_reg <= 5'h00;
                bpp_reg <= 2'h0;
            end else begin
                act_reg <= act;
                sel_reg <= bitoff[4:0];
                bpp_reg <= bpp;
            end
        end
        assign word = fb_data[j + 1] >> sel_reg;
        always_comb begin
            case (bpp_reg)
                2'h0: code = word[7:0];
                2'h1: code = {4'h0, word[3:0]};
                2'h2: code = {6'h00, word[1:0]};
                default: code = {7'h00, word[0]};
            endcase
            if (!act_reg)
                code = 8'h00; // [R15]
        end
    end

    // ==========================================================
    // Frame buffer lanes and first pipeline stage
    oog_video_s s1_vid, s2_vid;
    logic s1_cact, s1_glyph, s1_fb, s1_2col, s1_win_hit;
    logic [1:0] s1_on;
    logic [4:0] s1_cx;
    logic [23:0] s1_attr;
    logic [7:0] s1_win_col, s2_code;

    always_ff @(posedge clock) begin
        if (reset) begin
            fb_req <= '0;
        end else begin
            fb_req.rd <= {g_bmp[1].act, g_bmp[0].act, char_act && fb_font && glyph_in};
            fb_req.addr[0] <= cfg_reg[`OOG_FBFONT0 + rattr[1:0]][23:0] +
                              {16'h0000, idx} * {19'h00000, gh} + {19'h00000, cy_reg}; // [R10] [R11]
            fb_req.addr[1] <= cfg_reg[`OOG_BMP0][23:0] + {6'h00, g_bmp[0].bitoff[22:5]};
            fb_req.addr[2] <= cfg_reg[`OOG_BMP0 + 4][23:0] + {6'h00, g_bmp[1].bitoff[22:5]};
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s1_vid <= '0;
            s1_cact <= 1'b0;
            s1_glyph <= 1'b0;
            s1_fb <= 1'b0;
            s1_2col <= 1'b0;
            s1_on <= 2'h0;
            s1_cx <= 5'h00;
            s1_attr <= 24'h000000;
            s1_win_hit <= 1'b0;
            s1_win_col <= 8'h00;
        end else begin
            s1_vid <= video_in;
            s1_cact <= char_act;
            s1_glyph <= glyph_in;
            s1_fb <= fb_font;
            s1_2col <= rattr[3];
            s1_on <= on_code;
            s1_cx <= cx_reg;
            s1_attr <= attr;
            s1_win_hit <= win_hit;
            s1_win_col <= win_col;
        end
    end

    // ==========================================================
    // Colour resolution
    logic [31:0] fbsh;
    logic [1:0] pcode;
    logic one_bit, is_fore, blank;
    logic [7:0] c1, c2, c3, fore_col, back_col, char_code, merged;

    assign fbsh = fb_data[0] >> {s1_cx, 1'b0};
    assign pcode = !s1_glyph ? 2'h0 : (s1_fb ? fbsh[1:0] : s1_on); // [R14]
    assign one_bit = s1_fb ? s1_2col : !ctrl[`OOG_TWO_BIT];
    assign c3 = {s1_attr[23:20], s1_attr[19:17], 1'b0}; // [R6]
    assign c2 = {s1_attr[23:20], s1_attr[15:12]}; // [R6]
    assign c1 = {s1_attr[23:20], s1_attr[11:9], 1'b0}; // [R7]
    assign is_fore = one_bit ? pcode[1] : (pcode != 2'h0);
    assign blank = s1_attr[8] && blink_off; // [R3]

    always_comb begin
        case (pcode)
            2'h3: fore_col = c3; // [R8]
            2'h2: fore_col = c2; // [R8]
            default: fore_col = c1; // [R8]
        endcase
        if (one_bit)
            fore_col = s1_attr[23:16]; // [R1]
        if (s1_win_hit)
            back_col = s1_win_col; // [R12]
        else if (!one_bit)
            back_col = c2; // [R13]
        else if (s1_fb)
            back_col = {s1_attr[7:1], 1'b0}; // [R5]
        else
            back_col = {s1_attr[15:9], 1'b0}; // [R1] [R2] [R13]
    end

    assign char_code = !s1_cact ? 8'h00 : ((is_fore && !blank) ? fore_col : back_col); // [R4]
    assign merged = (char_code != 8'h00) ? char_code :
                    ((g_bmp[1].code != 8'h00) ? g_bmp[1].code : g_bmp[0].code); // [R17]

    always_ff @(posedge clock) begin
        if (reset) begin
            s2_code <= 8'h00;
            s2_vid <= '0;
        end else begin
            s2_code <= merged;
            s2_vid <= s1_vid;
        end
    end

    // ==========================================================
    // Colour table and blend
    logic [23:0] ovl;
    logic [3:0] lvl;
    wire [23:0] mix;

    assign ovl = clut_mem[s2_code]; // [R16]
    assign lvl = s2_code[7] ? cfg_reg[`OOG_BLEND][7:4] : cfg_reg[`OOG_BLEND][3:0]; // [R19]
    for (genvar k = 0; k < 3; k++) begin : g_mix
        logic [12:0] sum;
        assign sum = {5'h00, ovl[8 * k +: 8]} * (13'h0010 - {9'h000, lvl}) +
                     {5'h00, s2_vid.rgb[8 * k +: 8]} * {9'h000, lvl}; // [R20]
        assign mix[8 * k +: 8] = sum[11:4];
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            video_out <= '0;
        end else begin
            video_out <= s2_vid;
            if (s2_code != 8'h00)
                video_out.rgb <= mix; // [R16] [R19]
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_pipe_delay: assert property (!$past(reset, 1) && !$past(reset, 2) && !$past(reset, 3) |->
        video_out.den == $past(video_in.den, 3)) else $error("output enable not aligned");
    a_clear_passes: assert property (s2_code == 8'h00 |=> // [R16]
        video_out.rgb == $past(s2_vid.rgb)) else $error("transparent code altered the image");
    a_opaque_blend: assert property (s2_code != 8'h00 && lvl == 4'h0 |=> // [R20]
        video_out.rgb == $past(ovl)) else $error("code zero blend not opaque");
    a_back_lsb: assert property (s1_cact && one_bit && !s1_win_hit && !is_fore && !s1_fb |-> // [R2]
        char_code == {s1_attr[15:9], 1'b0}) else $error("one-bit background wrong");
    a_blink_blank: assert property (s1_cact && blank |-> char_code == back_col) // [R4]
        else $error("blinking foreground not blanked");
    a_color_one: assert property (s1_cact && !one_bit && pcode == 2'h1 && !blank |-> // [R7]
        char_code == c1 && !char_code[0]) else $error("colour 1 wrong");
    a_blink_frame: assert property (!vs_rise |=> $stable(blink_cnt_reg)) // [R23]
        else $error("blink counter moved outside frame edge");
    a_map_incr: assert property (access && mapped && widx == `OOG_MAPDATA |=>
        cfg_reg[`OOG_MAPADDR] == $past(cfg_reg[`OOG_MAPADDR]) + 32'h0000_0001)
        else $error("map address did not advance");
    a_font_lane: assert property (fb_req.rd[0] |-> $past(char_act && fb_font && glyph_in)) // [R22]
        else $error("font fetch without frame-buffer row");
    a_unmapped_zero: assert property (setup && !mapped |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    c_blink_blank: cover property (s1_cact && blank && s1_attr[8]);
    c_font_fetch: cover property (fb_req.rd[0] ##1 s1_fb);
    c_window_hit: cover property (s1_cact && s1_win_hit && s1_win_col != 8'h00);
    c_partial_blend: cover property (s2_code != 8'h00 && lvl != 4'h0);
endmodule : oog_overlay_generator

//--- bench/oog_fb_model.sv
// Frame buffer model answering every read lane in the same cycle as its registered request
`timescale 1ns/10ps
module oog_fb_model (
    input wire logic clock, // Pixel clock
    input wire oog_pkg::oog_fb_req_s fb_req, // Read lanes
    output oog_pkg::oog_fb_word_t fb_data // Word in the same cycle as the request
);
    import oog_pkg::*;
    // Every stored 8-bit bitmap word holds codes 01, 00, 81, 00
    localparam logic [31:0] BMP_WORD = 32'h0081_0001;
    oog_fb_word_t idle_reg = '0;
    // Idle lanes toggle so a stale word is never mistaken for data
    always @(posedge clock) begin
        idle_reg <= ~idle_reg;
    end
    // The generator consumes the word in the cycle its registered request is shown
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            fb_data[i] = fb_req.rd[i] ? BMP_WORD : idle_reg[i];
        end
    end
endmodule : oog_fb_model

//--- bench/oog_overlay_generator_tb.sv
// Self-checking bench: APB registers, colour table, bitmap and character blending
`timescale 1ns/10ps
module oog_overlay_generator_tb;
    import oog_pkg::*;
    localparam logic [23:0] IN_RGB = 24'h40C080;
    localparam logic [23:0] COL_LO = 24'h1080F0;
    localparam logic [23:0] COL_HI = 24'hF02000;
    localparam logic [23:0] COL_BG = 24'h30A050;
    logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err;
    oog_video_s video_in = '0, video_out;
    oog_fb_req_s fb_req;
    oog_fb_word_t fb_data;
    int num_errors = 0, check_count = 0, cycles = 0;
    always #50 clock = ~clock;
    oog_overlay_generator u_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .video_in(video_in), .video_out(video_out), .fb_req(fb_req),
        .fb_data(fb_data));
    oog_fb_model u_fb (.clock(clock), .fb_req(fb_req), .fb_data(fb_data));
    // ==========
    // Helpers
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [23:0] mix(input logic [23:0] o, input logic [23:0] i, input int l);
        for (int b = 0; b < 24; b += 8) mix[b+:8] = 8'((o[b+:8] * (16 - l) + i[b+:8] * l) >> 4);
    endfunction : mix
    // ==========
    // Scenarios
    task test_regs;
        apb(1'b0, 12'h000, '0);
        check(rd, 32'h0);
        apb(1'b1, 12'h008, 32'h0000_00F0);
        apb(1'b0, 12'h008, '0);
        check(rd, 32'h0000_00F0);
        apb(1'b0, 12'h03C, '0);
        check({err, rd[30:0]}, 32'h8000_0000);
    endtask : test_regs
    task frame(input int lo, input int hi, input logic chr);
        logic [23:0] exp, col;
        logic [7:0] code;
        apb(1'b1, 12'h008, {24'h0, 4'(hi), 4'(lo)});
        @(posedge clock);
        video_in <= '{den: 1'b0, hs: 1'b0, vs: 1'b1, rgb: IN_RGB};
        @(posedge clock);
        video_in.vs <= 1'b0;
        for (int i = 0; i < 19; i++) begin
            @(posedge clock);
            video_in.den <= (i < 16);
            #1;
            if (!chr && i >= 1 && i <= 16)
                check({7'h0, fb_req.rd[1], fb_req.addr[1]}, {8'h01, 24'((i - 1) / 4)});
            if (i >= 3) begin
                code = 8'(32'h0081_0001 >> (8 * ((i - 3) % 4)));
                if (chr) code = (i == 3) ? 8'h81 : ((i == 4) ? 8'h02 : 8'h00);
                col = (code == 8'h01) ? COL_LO : ((code == 8'h81) ? COL_HI : COL_BG);
                exp = mix(col, IN_RGB, code[7] ? hi : lo);
                if (code == 8'h00) exp = IN_RGB;
                check({7'h0, video_out.den, video_out.rgb}, {8'h01, exp});
            end
        end
    endtask : frame
    task test_blend;
        apb(1'b1, 12'h030, 32'h01);
        apb(1'b1, 12'h034, {8'h0, COL_LO});
        apb(1'b1, 12'h030, 32'h81);
        apb(1'b1, 12'h034, {8'h0, COL_HI});
        apb(1'b1, 12'h050, 32'h0);
        apb(1'b1, 12'h054, 32'h0);
        apb(1'b1, 12'h058, 32'h0004_0010);
        apb(1'b1, 12'h05C, 32'h0);
        apb(1'b1, 12'h000, 32'h10);
        frame(0, 15, 1'b0);
        frame(15, 0, 1'b0);
        frame(8, 3, 1'b0);
    endtask : test_blend
    task test_char;
        apb(1'b1, 12'h00C, 32'h0102_0101);
        apb(1'b1, 12'h014, 32'h10);
        apb(1'b1, 12'h028, 32'h0);
        apb(1'b1, 12'h02C, 32'h0);
        apb(1'b1, 12'h02C, 32'h0081_0302);
        apb(1'b1, 12'h028, 32'h22);
        apb(1'b1, 12'h02C, 32'h0000_0001);
        apb(1'b1, 12'h028, 32'h22);
        apb(1'b0, 12'h02C, '0);
        check(rd, 32'h0000_0001);
        apb(1'b1, 12'h030, 32'h02);
        apb(1'b1, 12'h034, {8'h0, COL_BG});
        apb(1'b1, 12'h000, 32'h01);
        frame(4, 0, 1'b1);
    endtask : test_char
    // ==========
    // Run control
    task close_out;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out;
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        test_regs;
        test_blend;
        test_char;
        close_out;
    end
endmodule : oog_overlay_generator_tb
